// ---- hdl/bsi_pkg.sv ----
/*
 Shared constants for the backplane slot interface: bus widths, slot decode
 field, interrupt level assignments and acknowledge timing.
 Assumes a single 10 MHz clock and synchronous backplane inputs.
*/
package bsi_pkg;
    localparam int ADDR_W      = 22;            // Word address lines
    localparam int DATA_W      = 16;            // Data lines, bit 15 is MSB
    localparam int SLOT_W      = 4;             // Slot identity width
    localparam int SLOT_LSB    = 18;            // Index of line 19 within 1-based lines
    localparam int LOCAL_W     = 18;            // 256k words per card
    localparam int MEM_AW      = 8;             // Implemented local words
    localparam int IRQ_LEVELS  = 7;             // Request lines
    localparam int LVL_ACQ     = 1;             // Acquisition busy/done
    localparam int LVL_OVLD    = 2;             // Channel input overload
    localparam int LVL_KNOB    = 3;             // Rotary knob change
    localparam int LVL_KEYS    = 4;             // Keyboard
    localparam int LVL_IBUS    = 5;             // Instrument bus interface
    localparam int LVL_TIMER   = 6;             // Processor timer (host-side source)
    localparam int CLK_NS      = 100;           // Clock period
    localparam int ACK_LAT_NS  = 200;           // Least time from strobe to ack
    localparam int ACK_LAT_CYC = (ACK_LAT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000; // Data-out register reset value
    localparam logic [MEM_AW-1:0] RUN_WORD = 8'hFF;    // Local word holding run bit
    localparam int    RUN_BIT  = 0;             // Run bit inside that word
    typedef enum logic [1:0] {BSI_IDLE, BSI_WAIT, BSI_ACK} bsi_state_e;
endpackage : bsi_pkg

// ---- hdl/bsi_slot.sv ----
/*
 Plug-in card end of the backplane bus: slot decode, word/byte transfers,
 open-collector interrupt requests with a daisy chain, trigger and run lines.
 A fixed-latency sequencer answers each selected cycle that has a byte strobe with a transfer acknowledge; a 256-word store
 stands in for the card's local space and is aliased over the whole window.
 Open-collector pins are a constant low level plus a pull enable, so the
 board wiring resolves the shared lines.
 Assumes the host keeps its strobe protocol and that all inputs are
 synchronous to ref_clk_in. The host's bus-fault timer is outside this
 block; a cycle that this card refuses is ended by that timer.
 Strobe, address and direction must stand steady from the taking edge
 until the strobe is negated.
*/
// Overview of operation
// - Answer only when upper address equals slot
// - Memory mapped, twenty-two word address lines
// - Sixteen data bits, bit fifteen most significant
// - Open-collector low requests, level seven highest
// - Fixed level per event source
// - Chain enable in, forwarded enable out
// - Group trigger command sets trigger flag
// - Run level from control bit, low stops
// - Selected card pulls transfer acknowledge low
`timescale 1ns/1ns
module bsi_slot
    import bsi_pkg::*;
(
    input  wire logic                     ref_clk_in,               // 10 MHz clock
    input  wire logic                     arst_n_in,                // Async reset, low
    input  wire logic [SLOT_W-1:0]        slot_id_in,               // Slot identity strap
    input  wire logic [bsi_pkg::ADDR_W:1] word_address_lines_in,    // Word address
    input  wire logic [DATA_W-1:0]        bus_data_lines_in,        // Data from bus
    output logic      [DATA_W-1:0]        bus_data_lines_out,       // Data to bus
    output logic                          bus_data_lines_oe_out,    // Data drive enable
    input  wire logic                     addr_strobe_n_in,         // Address strobe
    input  wire logic                     upper_byte_strobe_n_in,   // Upper byte strobe
    input  wire logic                     lower_byte_strobe_n_in,   // Lower byte strobe
    input  wire logic                     read_not_write_in,        // High = read
    output logic                          transfer_ack_n_out,       // Always low when driven
    output logic                          transfer_ack_oe_out,      // Ack pull enable
    input  wire logic [IRQ_LEVELS:1]      event_in,                 // Event pulses per level
    output logic      [IRQ_LEVELS:1]      irq_level_lines_n_out,    // Always low when driven
    output logic      [IRQ_LEVELS:1]      irq_level_lines_oe_out,   // Request pull enables
    input  wire logic                     irq_chain_enable_in,      // Chain enable in
    output logic                          irq_chain_enable_out,     // Chain enable out
    input  wire logic                     irq_ack_n_in,             // Interrupt acknowledge
    input  wire logic                     group_trigger_cmd_in,     // Group execute trigger seen
    input  wire logic                     group_trigger_clr_in,     // Clear trigger flag
    output logic                          group_trigger_flag_out,   // Group trigger flag
    output logic                          acquire_run_level_out     // High run, low stop
);
    import bsi_pkg::*;

    // Sequencer state and its latency counter
    bsi_state_e         state_q, state_d;
    logic [1:0]         wait_q;
    logic [IRQ_LEVELS:1] pend_q;
    // Miscellaneous line registers
    logic               trig_q;
    logic               run_q;
    // Registered read data from the local store
    logic [DATA_W-1:0]  rdata;

    // Slot match on the top four word address lines
    wire                slot_hit  = word_address_lines_in[ADDR_W -: SLOT_W] == slot_id_in;
    // Only the low word lines reach the store; the rest alias on purpose
    wire [MEM_AW-1:0]   word_idx  = word_address_lines_in[MEM_AW:1];
    // A cycle for this card needs the strobe and a matching slot
    wire                cyc       = !addr_strobe_n_in && slot_hit;
    // Byte lanes, upper strobe in bit one
    wire [1:0]          lanes     = {!upper_byte_strobe_n_in, !lower_byte_strobe_n_in};
    wire                any_lane  = |lanes;

    // Latency reached: the edge that commits data and enters acknowledge
    wire                wait_done = state_q == BSI_WAIT
                                    && wait_q == 2'(ACK_LAT_CYC - 1);
    wire                answering = state_q == BSI_ACK;
    // Writes land once, so a long strobe never repeats a byte-lane write
    wire                do_write  = wait_done && !read_not_write_in;
    wire [1:0]          mem_we    = do_write ? lanes : 2'b00;
    // The run bit rides on the lower lane of one fixed control word
    wire                run_wr    = do_write && word_idx == RUN_WORD && lanes[0];
    // Read data refreshed every wait cycle, so the last fetch stands at ack
    wire                rd_load   = state_q == BSI_WAIT && read_not_write_in;

    // Local store; its read port is registered, hence the fixed latency

    bsi_word_mem u_mem (
        .ref_clk_in (ref_clk_in),
        .addr_in    (word_idx),
        .we_in      (mem_we),
        .wdata_in   (bus_data_lines_in),
        .rdata_out  (rdata)
    );

    // Cycle sequencer: wait a fixed latency, acknowledge, hold until strobe drops.
    // A cycle that loses its strobe or slot while waiting is dropped with no
    // acknowledge, leaving the host's fault timer to end it; if that happens in
    // the last wait cycle, the write still lands.
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            BSI_IDLE:
            begin
                if (cyc && any_lane)
                    state_d = BSI_WAIT;
            end
            BSI_WAIT:
            begin
                if (!cyc)
                    state_d = BSI_IDLE;
                else if (wait_done)
                    state_d = BSI_ACK;
            end
            BSI_ACK:
            begin
                // Ack holds until the host negates the strobe
                if (addr_strobe_n_in)
                    state_d = BSI_IDLE;
            end
        endcase
    end

    // State register; the wait counter restarts on every new cycle
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_q <= BSI_IDLE;
            wait_q  <= 2'h0;
        end
        else
        begin
            state_q <= state_d;
            wait_q  <= (state_q == BSI_WAIT) ? wait_q + 2'h1 : 2'h0;
        end
    end

    // Ack is an open-collector pull, only while the cycle is answered
    assign transfer_ack_n_out  = 1'b0;
    assign transfer_ack_oe_out = answering;

    // Data drive only for a selected read. Both lanes are driven on a read;
    // the host ignores the lane it did not strobe, which keeps the mux small.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            bus_data_lines_out <= DATA_RST;
        else if (rd_load)
            bus_data_lines_out <= rdata;
    end
    // Enable drops with the strobe at once, before ack is released
    assign bus_data_lines_oe_out = answering && read_not_write_in
                                   && !addr_strobe_n_in;

    // Sticky requests per level; a new event beats the acknowledge clear.
    // Only the highest pending level of this card clears per acknowledge,
    // so lower requests stay up and are served on later acknowledges.
    wire ack_take = !irq_ack_n_in && irq_chain_enable_in;
    genvar l;
    generate
        for (l = 1; l <= IRQ_LEVELS; l++)
        begin : g_irq
            // Levels above this one still pending on this card
            wire higher = |(pend_q >> l);
            wire clr    = ack_take && pend_q[l] && !higher;           // Highest only
            always_ff @(posedge ref_clk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                begin
                    pend_q[l] <= 1'b0;
                end
                else
                begin
                    pend_q[l] <= event_in[l] | (pend_q[l] & !clr);
                end
            end
            // Pull the shared line only while this level is pending
            assign irq_level_lines_n_out[l]  = 1'b0;
            assign irq_level_lines_oe_out[l] = pend_q[l];
        end
    endgenerate

    // Chain passes enable on only when this card is not claiming the acknowledge.
    // Combinational on purpose: a registered chain would add a cycle per card
    // and could let two cards take the same acknowledge.
    assign irq_chain_enable_out = irq_chain_enable_in && !(|pend_q);

    // Group trigger flag: set wins over clear, so a command arriving with a
    // clear is never lost
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            trig_q <= 1'b0;
        else
            trig_q <= group_trigger_cmd_in | (trig_q & !group_trigger_clr_in);
    end
    assign group_trigger_flag_out = trig_q;

    // Run bit lives in a control word; reset leaves acquisition stopped.
    // The bit is write-only here: reads of that word return the store copy.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            run_q <= 1'b0;
        else if (run_wr)
            run_q <= bus_data_lines_in[RUN_BIT];
    end
    assign acquire_run_level_out = run_q;
endmodule : bsi_slot

// ---- hdl/bsi_word_mem.sv ----
/*
 Small word memory behind the slot: byte-lane writes, registered read data.
 Assumes the caller qualifies every access.
*/
`timescale 1ns/1ns
module bsi_word_mem
    import bsi_pkg::*;
(
    input  wire logic              ref_clk_in,    // System clock
    input  wire logic [MEM_AW-1:0] addr_in,       // Word index
    input  wire logic [1:0]        we_in,         // Byte write enables, [1]=upper
    input  wire logic [DATA_W-1:0] wdata_in,      // Write data
    output logic      [DATA_W-1:0] rdata_out      // Registered read data
);
    logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];

    // Each lane written only under its own strobe
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_lane
            always_ff @(posedge ref_clk_in)
            begin
                if (we_in[g])
                    mem[addr_in][g*8 +: 8] <= wdata_in[g*8 +: 8];
            end
        end
    endgenerate

    // Read port registered so data meets the output flops directly
    always_ff @(posedge ref_clk_in)
    begin
        rdata_out <= mem[addr_in];
    end
endmodule : bsi_word_mem

// ---- verification/bsi_host_model.sv ----
/*
 Host processor model: strobed word/byte cycles and the bus-error timer.
 Assumes a card acks through ack_oe_in; released lines float high (pull-ups).
*/
`timescale 1ns/1ns
module bsi_host_model
    import bsi_pkg::*;
(
    input  wire logic              ref_clk_in,       // Clock
    input  wire logic              ack_oe_in,        // Card pulls ack
    output logic                   as_n_out,         // Address strobe
    output logic [1:0]             ds_n_out,         // Byte strobes, [1]=upper
    output logic                   rnw_out,          // High = read
    output logic [ADDR_W:1]        addr_out,         // Word address
    output logic [DATA_W-1:0]      data_out,         // Write data
    output logic                   bus_fault_n_out   // Low = no ack seen
);
    initial {as_n_out, ds_n_out, rnw_out, addr_out, data_out, bus_fault_n_out} = '1;
    // One bus cycle; 500 clocks is the 50 us fault limit, so a hang cannot occur
    task automatic cycle(input logic rd, input logic [ADDR_W:1] a, input logic [1:0] be,
                         input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        #10;
        {rnw_out, addr_out, data_out} = {rd, a, rd ? 16'hFFFF : d};
        as_n_out = 1'b0;
        ds_n_out = ~be;
        do
        begin
            @(posedge ref_clk_in);
            n++;
        end while (!ack_oe_in && n < 500);
        bus_fault_n_out = ack_oe_in;
        #10;
        {as_n_out, ds_n_out, rnw_out, addr_out, data_out} = '1;
        repeat (2) @(posedge ref_clk_in);
    endtask : cycle
endmodule : bsi_host_model

// ---- verification/bsi_slot_sva.sv ----
/*
 Port-level checker for bsi_slot: ack timing, data float, requests, chain.
 Assumes the single clock domain of the slot and a bind by port name.
*/
`timescale 1ns/1ns
module bsi_slot_sva
    import bsi_pkg::*;
(
    input wire logic              ref_clk_in,             // Clock
    input wire logic              arst_n_in,              // Reset, low
    input wire logic [SLOT_W-1:0] slot_id_in,             // Slot strap
    input wire logic [ADDR_W:1]   word_address_lines_in,  // Address
    input wire logic              addr_strobe_n_in,       // Strobe
    input wire logic              read_not_write_in,      // Direction
    input wire logic              transfer_ack_n_out,     // Ack level
    input wire logic              transfer_ack_oe_out,    // Ack pull
    input wire logic              bus_data_lines_oe_out,  // Data drive
    input wire logic [7:1]        event_in,               // Events
    input wire logic [7:1]        irq_level_lines_n_out,  // Request level
    input wire logic [7:1]        irq_level_lines_oe_out, // Request pulls
    input wire logic              irq_chain_enable_in,    // Chain in
    input wire logic              irq_chain_enable_out,   // Chain out
    input wire logic              irq_ack_n_in,           // Int ack
    input wire logic              group_trigger_cmd_in,   // Trigger cmd
    input wire logic              group_trigger_flag_out, // Trigger flag
    input wire logic              acquire_run_level_out   // Run level
);
    // Slot match on the top four address lines
    wire sel = word_address_lines_in[ADDR_W:ADDR_W-3] == slot_id_in;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    a_ack_own_slot: assert property ($rose(transfer_ack_oe_out) |-> sel)
        else $error("ack for another slot");
    a_ack_latency_two: assert property ($fell(addr_strobe_n_in) && sel |-> ##[2:3] transfer_ack_oe_out)
        else $error("ack late");
    a_ack_released: assert property (addr_strobe_n_in [*2] |-> !transfer_ack_oe_out)
        else $error("ack held after strobe");
    a_data_float: assert property (bus_data_lines_oe_out |-> read_not_write_in && !addr_strobe_n_in && sel)
        else $error("data driven outside a read");
    a_pull_low_only: assert property (!transfer_ack_n_out && irq_level_lines_n_out == 7'h00)
        else $error("open collector level high");
    a_chain_gate: assert property (irq_chain_enable_out == (irq_chain_enable_in && !(|irq_level_lines_oe_out)))
        else $error("chain enable wrong");
    a_irq_latched: assert property (|event_in |=> (irq_level_lines_oe_out & $past(event_in)) == $past(event_in))
        else $error("event not raised");
    a_irq_clear_ack: assert property (($past(irq_level_lines_oe_out) & ~irq_level_lines_oe_out) != 7'h00 |-> $past(!irq_ack_n_in))
        else $error("request dropped without ack");
    a_trig_set: assert property (group_trigger_cmd_in |=> group_trigger_flag_out)
        else $error("trigger flag not set");
    a_run_by_write: assert property ($changed(acquire_run_level_out) |-> transfer_ack_oe_out && !read_not_write_in)
        else $error("run level moved outside a write");
endmodule : bsi_slot_sva
bind bsi_slot bsi_slot_sva bsi_slot_sva_i (.*);

// ---- verification/test_backplane_slot_interface.sv ----
/*
 Self-checking bench for bsi_slot driven through the host model.
 Assumes slot identity 5 and the 2-cycle ack latency of the package.
*/
`timescale 1ns/1ns
module test_backplane_slot_interface;
    import bsi_pkg::*;
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", n, e, s); end end
    localparam logic [3:0] SID = 4'h5;
    logic clk = 0, rst_n = 0, as_n, rnw, fault_n, ack_oe, d_oe, ack_d = 0;
    logic chain_in = 1, chain_out, iack_n = 1, gcmd = 0, gclr = 0, flag, run;
    logic [1:0] ds_n;
    logic [7:1] ev = '0, irq_oe;
    logic [ADDR_W:1] addr;
    logic [15:0] wd, rd, r = 16'h9F05, expq[$];
    int mismatches = 0, comparisons = 0;
    always #50 clk = ~clk;
    bsi_host_model bsi_host_model_i (.ref_clk_in(clk), .ack_oe_in(ack_oe), .as_n_out(as_n),
        .ds_n_out(ds_n), .rnw_out(rnw), .addr_out(addr), .data_out(wd), .bus_fault_n_out(fault_n));
    bsi_slot bsi_slot_i (.ref_clk_in(clk), .arst_n_in(rst_n), .slot_id_in(SID),
        .word_address_lines_in(addr), .bus_data_lines_in(wd), .bus_data_lines_out(rd),
        .bus_data_lines_oe_out(d_oe), .addr_strobe_n_in(as_n), .upper_byte_strobe_n_in(ds_n[1]),
        .lower_byte_strobe_n_in(ds_n[0]), .read_not_write_in(rnw), .transfer_ack_n_out(),
        .transfer_ack_oe_out(ack_oe), .event_in(ev), .irq_level_lines_n_out(),
        .irq_level_lines_oe_out(irq_oe), .irq_chain_enable_in(chain_in),
        .irq_chain_enable_out(chain_out), .irq_ack_n_in(iack_n), .group_trigger_cmd_in(gcmd),
        .group_trigger_clr_in(gclr), .group_trigger_flag_out(flag), .acquire_run_level_out(run));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    // Read monitor at the falling edge, where the registered data has settled
    always @(negedge clk)
    begin
        ack_d <= ack_oe;
        if (ack_oe && !ack_d && rnw)
        begin
            if (expq.size() == 0) `CHK("unexpected read", 1'b0, 1'b1)
            else `CHK("read data", expq.pop_front(), d_oe ? rd : 16'hxxxx)
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        #10 rst_n = 1;
        for (int i = 0; i < 8; i++)
        begin
            r = lfsr(r);
            bsi_host_model_i.cycle(0, {SID, 10'h0, 8'(i * 37)}, 2'b11, r);
            bsi_host_model_i.cycle(0, {SID, 10'h0, 8'(i * 37)}, 2'b10, ~r);
            expq.push_back({~r[15:8], r[7:0]});
            bsi_host_model_i.cycle(1, {SID, 10'h0, 8'(i * 37)}, 2'b11, '0);
        end
        $display("word and byte transfers done");
        bsi_host_model_i.cycle(1, {SID + 4'h1, 18'h0}, 2'b11, '0);
        `CHK("fault other slot", 1'b0, fault_n)
        foreach (r[b])
        begin
            bsi_host_model_i.cycle(0, {SID, 18'hFF}, 2'b01, 16'(b & 1));
            `CHK("run level", b[0], run)
        end
        `CHK("fault own slot", 1'b1, fault_n)
        $display("slot decode and run line done");
        #10 gcmd = 1;
        @(posedge clk) #10 {gcmd, gclr} = 2'b01;
        `CHK("trigger set", 1'b1, flag)
        @(posedge clk) #10 gclr = 0;
        `CHK("trigger clear", 1'b0, flag)
        for (int k = 1; k <= 7; k++)
        begin
            @(posedge clk) #10 ev[k] = 1;
            @(posedge clk) #10 {ev, iack_n} = 8'h00;
            `CHK("request", 7'(1 << (k - 1)), irq_oe)
            `CHK("chain blocked", 1'b0, chain_out)
            @(posedge clk) #10 iack_n = 1;
            `CHK("request cleared", 7'h00, irq_oe)
        end
        $display("interrupt and trigger tests done");
        end_sim();
    end
    // Watchdog: the whole sequence needs about 800 clocks
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule : test_backplane_slot_interface
